// ===== src/cpu_pm_params.svh
// Purpose: Named constants for the core programming model block
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef CPU_PM_PARAMS_SVH
`define CPU_PM_PARAMS_SVH

// Status word field positions
`define SR_T_BIT 15
`define SR_S_BIT 13
`define SR_X_BIT 4
`define SR_N_BIT 3
`define SR_Z_BIT 2
`define SR_V_BIT 1
`define SR_C_BIT 0
// Implemented bits: trace, supervisor, 3-bit mask, X N Z V C
`define SR_VALID_MASK 16'hA71F
`define CCR_VALID_MASK 8'h1F
`define SR_RESET 16'h2700

// Register file
`define GPR_RESET 32'h0000_0000
`define PC_RESET 32'h0000_0000
`define SP_RESET 32'h0000_0000
`define SP_IDX 4'hF
`define STACK_REG 3'h7

// Post/predecrement steps
`define STEP_BYTE 32'h0000_0001
`define STEP_WORD 32'h0000_0002
`define STEP_LONG 32'h0000_0004

// Implied register selects
`define IMPL_SR 2'h0
`define IMPL_USP 2'h1
`define IMPL_SSP 2'h2

// Last beat index per size and bus width
`define LAST_ONE 2'h0
`define LAST_TWO 2'h1
`define LAST_FOUR 2'h3

`endif

// ===== src/cpu_pm_pkg.sv
// Purpose: Types shared by the programming model and address unit
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes: Encodings are internal to this block
`default_nettype none
package cpu_pm_pkg;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} size_t;
  typedef enum logic [3:0] {
    M_DREG = 4'h0, M_AREG = 4'h1, M_IND = 4'h2, M_POSTINC = 4'h3, M_PREDEC = 4'h4,
    M_DISP = 4'h5, M_INDEX = 4'h6, M_ABS_S = 4'h7, M_ABS_L = 4'h8, M_PC_DISP = 4'h9,
    M_PC_INDEX = 4'hA, M_IMM = 4'hB, M_QUICK = 4'hC, M_IMPLIED = 4'hD
  } eamode_t;
  typedef enum logic [2:0] {
    OP_ACCESS = 3'h0, OP_REG_WRITE = 3'h1, OP_CCR_WRITE = 3'h2, OP_SR_WRITE = 3'h3,
    OP_USP_WRITE = 3'h4, OP_PC_WRITE = 3'h5
  } op_t;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_BUS = 3'b010, ST_DONE = 3'b100} state_t;
endpackage : cpu_pm_pkg
`default_nettype wire

// ===== src/ea_if.sv
// Purpose: Carries one address calculation between core and address unit
// Assumes: Purely combinational exchange within one cycle
// Notes: Register values are fetched by the core side
`default_nettype none
interface ea_if;
  import cpu_pm_pkg::*;
  eamode_t mode;
  size_t size;
  logic isStack;
  logic [31:0] baseVal, idxVal, pc, implVal;
  logic idxLong;
  logic [15:0] ext0, ext1;
  logic [7:0] quick;
  logic [31:0] ea, operand, wbVal;
  logic isMem, wbEn;
  modport calc (input mode, size, isStack, baseVal, idxVal, pc, implVal, idxLong,
                input ext0, ext1, quick, output ea, operand, wbVal, isMem, wbEn);
  modport user (output mode, size, isStack, baseVal, idxVal, pc, implVal, idxLong,
                output ext0, ext1, quick, input ea, operand, wbVal, isMem, wbEn);
endinterface : ea_if
`default_nettype wire

// ===== src/ea_calc.sv
// Purpose: Effective address and operand formation for all fourteen modes
// Assumes: Caller supplies base, index and implied register values
// Notes: Combinational; memory modes return no operand
`default_nettype none
`include "cpu_pm_params.svh"
module ea_calc (
  // Calculation port
  ea_if.calc ep
);
  import cpu_pm_pkg::*;
  logic [31:0] step;
  logic [31:0] idxExt;
  logic [31:0] d8;
  logic [31:0] d16;
  logic [31:0] immVal;

  // Stack stays word aligned, so bytes step by two there
  always_comb begin
    step = `STEP_LONG;
    if (ep.size == SZ_BYTE) begin
      step = ep.isStack ? `STEP_WORD : `STEP_BYTE;
    end else if (ep.size == SZ_WORD) begin
      step = `STEP_WORD;
    end
  end

  // Index is any register, word index sign extended
  assign idxExt = ep.idxLong ? ep.idxVal : 32'($signed(ep.idxVal[15:0]));
  assign d8 = 32'($signed(ep.ext0[7:0]));
  assign d16 = 32'($signed(ep.ext0));
  assign immVal = (ep.size == SZ_LONG) ? {ep.ext0, ep.ext1} :
                  (ep.size == SZ_WORD) ? {16'h0000, ep.ext0} : {24'h00_0000, ep.ext0[7:0]};

  // Mode decode
  always_comb begin
    ep.ea = 32'h0000_0000;
    ep.operand = 32'h0000_0000;
    ep.wbVal = ep.baseVal;
    ep.isMem = 1'b1;
    ep.wbEn = 1'b0;
    case (ep.mode)
      M_DREG, M_AREG: begin
        ep.isMem = 1'b0;
        ep.operand = (ep.size == SZ_LONG) ? ep.baseVal :
                     (ep.size == SZ_WORD) ? {16'h0000, ep.baseVal[15:0]} :
                     {24'h00_0000, ep.baseVal[7:0]};
      end
      M_IND: ep.ea = ep.baseVal;
      M_POSTINC: begin
        ep.ea = ep.baseVal;
        ep.wbEn = 1'b1;
        ep.wbVal = ep.baseVal + step;
      end
      M_PREDEC: begin
        ep.ea = ep.baseVal - step;
        ep.wbEn = 1'b1;
        ep.wbVal = ep.baseVal - step;
      end
      M_DISP: ep.ea = ep.baseVal + d16;
      M_INDEX: ep.ea = ep.baseVal + idxExt + d8;
      M_ABS_S: ep.ea = d16;
      M_ABS_L: ep.ea = {ep.ext0, ep.ext1};
      M_PC_DISP: ep.ea = ep.pc + d16;
      M_PC_INDEX: ep.ea = ep.pc + idxExt + d8;
      M_IMM: begin
        ep.isMem = 1'b0;
        ep.operand = immVal;
      end
      M_QUICK: begin
        ep.isMem = 1'b0;
        ep.operand = 32'($signed(ep.quick));
      end
      M_IMPLIED: begin
        ep.isMem = 1'b0;
        ep.operand = ep.implVal;
      end
      default: ep.isMem = 1'b0;
    endcase
  end
endmodule : ea_calc
`default_nettype wire

// ===== src/cpu_prog_model.sv
// Purpose: Core programming model, privilege, address modes and bus strobes
// Assumes: Strap level steady while running; one request at a time
// Notes: Opcode decode, timing and exceptions live elsewhere
// Overview of operation
// - Strap low selects 8-bit data bus, otherwise 16-bit bus.
// - In 8-bit mode upper strobe pin carries A0, lower pin is the byte strobe.
// - User and supervisor states; privileged operations refused in user state.
// - Sixteen 32-bit general registers, 32-bit program counter, 8-bit flags byte.
// - Data registers operate on low 8, low 16 or all 32 bits.
// - Address registers serve as pointers and bases, word and long only.
// - Any of the sixteen registers can be the index register.
// - Supervisor has own stack pointer; stack references follow privilege state.
// - Status word holds 3-bit mask, X N Z V C, trace and supervisor bits.
// - Operands are bytes, words and long words.
// - Fourteen addressing modes in six groups.
// - Register direct uses a register; absolute short/long use extension words.
// - Register indirect: plain, postincrement, predecrement, d16, index plus d8.
// - Immediate from extension words, quick from instruction, implied SR/SP/PC.
// - Steps are 1, 2, 4; stack byte access steps by 2.
`default_nettype none
`include "cpu_pm_params.svh"
module cpu_prog_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Strap
  input wire logic busWidthSel,
  // Request
  input wire logic opValid,
  input wire cpu_pm_pkg::op_t opCode,
  input wire cpu_pm_pkg::eamode_t opMode,
  input wire cpu_pm_pkg::size_t opSize,
  input wire logic [2:0] opReg,
  input wire logic [3:0] opIdxReg,
  input wire logic opIdxLong,
  input wire logic [3:0] opDst,
  input wire logic [15:0] opExt0,
  input wire logic [15:0] opExt1,
  input wire logic [7:0] opQuick,
  input wire logic [31:0] opData,
  // Answer
  output logic opReady,
  output logic opDone,
  output logic opRefused,
  output logic [31:0] eaOut,
  output logic [31:0] operandOut,
  // External bus
  output logic busValid,
  output logic [31:0] busAddr,
  output logic upperByteStrobeN,
  output logic lowerByteStrobeN,
  // Register view
  input wire logic [3:0] rdSel,
  output logic [31:0] rdData,
  output logic [15:0] statusWord,
  output logic [31:0] pcOut,
  output logic supervisorMode
);
  import cpu_pm_pkg::*;

  state_t state_r, stateNxt;
  logic [31:0] gpr_r [0:14];
  logic [31:0] usp_r, ssp_r, pc_r, accAddr_r;
  logic [15:0] sr_r;
  logic [1:0] beatCnt_r, beatLast;
  size_t accSize_r;
  logic busWide_r, refused_r;
  logic superOn, accept, privOp, sizeBad, refuse, doIt, memOp, wrEn, inBus;
  logic uspWr, sspWr;
  logic [3:0] wrIdx;
  logic [31:0] activeSp, oldVal, wrVal, beatAddr;
  logic upNxt, loNxt;
  ea_if eaIf ();

  // Register read; index 15 is whichever stack pointer is live
  function automatic logic [31:0] regVal(input logic [3:0] idx);
    regVal = (idx == `SP_IDX) ? activeSp : gpr_r[idx];
  endfunction : regVal

  ea_calc u_ea (
    .ep(eaIf)
  );

  // Privilege and request qualification
  assign superOn = sr_r[`SR_S_BIT];
  assign activeSp = superOn ? ssp_r : usp_r;
  assign accept = opValid && (state_r == ST_IDLE);
  assign privOp = (opCode == OP_SR_WRITE) || (opCode == OP_USP_WRITE) ||
                  (opCode == OP_ACCESS && opMode == M_IMPLIED && opReg[1:0] == `IMPL_SSP);
  assign sizeBad = (opSize == SZ_BYTE) && ((opCode == OP_REG_WRITE && opDst[3]) ||
                   (opCode == OP_ACCESS && opMode == M_AREG));
  assign refuse = (privOp && !superOn) || sizeBad;
  assign doIt = accept && !refuse;
  assign memOp = (opCode == OP_ACCESS) && eaIf.isMem;

  // Address unit feed
  assign eaIf.mode = opMode;
  assign eaIf.size = opSize;
  assign eaIf.isStack = (opReg == `STACK_REG) && (opMode != M_DREG);
  assign eaIf.baseVal = regVal({opMode != M_DREG, opReg});
  assign eaIf.idxVal = regVal(opIdxReg);
  assign eaIf.idxLong = opIdxLong;
  assign eaIf.pc = pc_r;
  assign eaIf.ext0 = opExt0;
  assign eaIf.ext1 = opExt1;
  assign eaIf.quick = opQuick;
  assign eaIf.implVal = (opReg[1:0] == `IMPL_SR) ? {16'h0000, sr_r} :
                        (opReg[1:0] == `IMPL_USP) ? usp_r :
                        (opReg[1:0] == `IMPL_SSP) ? ssp_r : pc_r;

  // Single register write port: explicit writes and pointer writeback
  assign wrEn = doIt && ((opCode == OP_REG_WRITE) || (opCode == OP_ACCESS && eaIf.wbEn));
  assign wrIdx = (opCode == OP_REG_WRITE) ? opDst : {1'b1, opReg};
  assign oldVal = regVal(wrIdx);

  // Size merge; address registers sign extend words
  always_comb begin
    wrVal = eaIf.wbVal;
    if (opCode == OP_REG_WRITE) begin
      if (opDst[3]) begin
        wrVal = (opSize == SZ_WORD) ? 32'($signed(opData[15:0])) : opData;
      end else begin
        case (opSize)
          SZ_BYTE: wrVal = {oldVal[31:8], opData[7:0]};
          SZ_WORD: wrVal = {oldVal[31:16], opData[15:0]};
          default: wrVal = opData;
        endcase
      end
    end
  end

  // Fifteen plain registers; the sixteenth is banked by privilege
  for (genvar i = 0; i < 15; i++) begin : g_gpr
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        gpr_r[i] <= `GPR_RESET;
      end else if (wrEn && wrIdx == 4'(i)) begin
        gpr_r[i] <= wrVal;
      end
    end
  end

  // Stack pointer bank selection
  assign uspWr = (wrEn && wrIdx == `SP_IDX && !superOn) || (doIt && opCode == OP_USP_WRITE);
  assign sspWr = wrEn && wrIdx == `SP_IDX && superOn;

  // Banked pointers, status word and program counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      usp_r <= `SP_RESET;
      ssp_r <= `SP_RESET;
      sr_r <= `SR_RESET;
      pc_r <= `PC_RESET;
    end else begin
      if (uspWr) usp_r <= (opCode == OP_USP_WRITE) ? opData : wrVal;
      if (sspWr) ssp_r <= wrVal;
      if (doIt && opCode == OP_SR_WRITE) sr_r <= opData[15:0] & `SR_VALID_MASK;
      if (doIt && opCode == OP_CCR_WRITE) sr_r[7:0] <= opData[7:0] & `CCR_VALID_MASK;
      if (doIt && opCode == OP_PC_WRITE) pc_r <= opData;
    end
  end

  // Strap is caught once at reset; later changes are not followed
  always_ff @(posedge clk_sys) begin
    if (rst) busWide_r <= busWidthSel;
  end

  // Beat count from operand size and bus width
  assign beatLast = busWide_r ? ((accSize_r == SZ_LONG) ? `LAST_TWO : `LAST_ONE) :
                    (accSize_r == SZ_LONG) ? `LAST_FOUR :
                    (accSize_r == SZ_WORD) ? `LAST_TWO : `LAST_ONE;
  assign beatAddr = accAddr_r + (busWide_r ? {29'h0, beatCnt_r, 1'b0} : {30'h0, beatCnt_r});
  assign inBus = (state_r == ST_BUS);
  // Narrow bus: upper pin is A0; wide bus: one strobe per lane
  assign upNxt = !inBus ? 1'b1 : (!busWide_r || accSize_r == SZ_BYTE) ? beatAddr[0] : 1'b0;
  assign loNxt = !inBus ? 1'b1 : !busWide_r ? 1'b0 :
                 (accSize_r == SZ_BYTE) ? !beatAddr[0] : 1'b0;

  // Sequencer
  always_comb begin
    stateNxt = state_r;
    case (state_r)
      ST_IDLE: if (accept) stateNxt = (doIt && memOp) ? ST_BUS : ST_DONE;
      ST_BUS: if (beatCnt_r == beatLast) stateNxt = ST_DONE;
      ST_DONE: stateNxt = ST_IDLE;
      default: stateNxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
      beatCnt_r <= `LAST_ONE;
      accAddr_r <= `GPR_RESET;
      accSize_r <= SZ_BYTE;
      refused_r <= 1'b0;
    end else begin
      state_r <= stateNxt;
      beatCnt_r <= inBus ? beatCnt_r + 2'h1 : `LAST_ONE;
      if (accept) begin
        accAddr_r <= eaIf.ea;
        accSize_r <= opSize;
        refused_r <= refuse;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      opReady <= 1'b1;
      opDone <= 1'b0;
      opRefused <= 1'b0;
      eaOut <= `GPR_RESET;
      operandOut <= `GPR_RESET;
      busValid <= 1'b0;
      busAddr <= `GPR_RESET;
      upperByteStrobeN <= 1'b1;
      lowerByteStrobeN <= 1'b1;
      rdData <= `GPR_RESET;
    end else begin
      opReady <= (stateNxt == ST_IDLE);
      opDone <= (state_r == ST_DONE);
      opRefused <= (state_r == ST_DONE) && refused_r;
      if (doIt) eaOut <= eaIf.ea;
      if (doIt) operandOut <= eaIf.operand;
      busValid <= inBus;
      if (inBus) busAddr <= beatAddr;
      upperByteStrobeN <= upNxt;
      lowerByteStrobeN <= loNxt;
      rdData <= regVal(rdSel);
    end
  end

  assign statusWord = sr_r;
  assign pcOut = pc_r;
  assign supervisorMode = sr_r[`SR_S_BIT];

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_STRAP_STABLE: assert property ($stable(busWide_r))
    else $error("bus width changed after reset");
  AST_NARROW_STROBE: assert property (busValid && !busWide_r |->
    !lowerByteStrobeN && (upperByteStrobeN == busAddr[0]))
    else $error("narrow bus strobe pins wrong");
  AST_WIDE_STROBE: assert property (busValid && busWide_r && accSize_r != SZ_BYTE |->
    !upperByteStrobeN && !lowerByteStrobeN)
    else $error("wide transfer missing a lane strobe");
  AST_PRIV_REFUSE: assert property (accept && opCode == OP_SR_WRITE && !superOn |->
    ##1 $stable(sr_r) ##1 (opRefused && opDone))
    else $error("user status write not refused");
  AST_ABYTE_REFUSE: assert property (accept && opCode == OP_REG_WRITE && opDst[3] &&
    opSize == SZ_BYTE |-> ##2 opRefused)
    else $error("byte write to address register accepted");
  AST_NARROW_LONG: assert property (doIt && memOp && opSize == SZ_LONG && !busWide_r |->
    ##2 busValid [*4] ##1 !busValid ##0 opDone)
    else $error("narrow long access not four beats");
  AST_WIDE_LONG: assert property (doIt && memOp && opSize == SZ_LONG && busWide_r |->
    ##2 busValid [*2] ##1 !busValid)
    else $error("wide long access not two beats");
  AST_STACK_BYTE: assert property (doIt && opCode == OP_ACCESS && opMode == M_POSTINC &&
    opReg == `STACK_REG && opSize == SZ_BYTE && !superOn |=> usp_r == $past(usp_r) + `STEP_WORD)
    else $error("stack byte step not two");
  AST_PREDEC: assert property (doIt && opMode == M_PREDEC && opSize == SZ_LONG &&
    opCode == OP_ACCESS && opReg != `STACK_REG |=> eaOut == $past(eaIf.baseVal) - `STEP_LONG)
    else $error("predecrement address wrong");
  AST_PC_DISP: assert property (doIt && opCode == OP_ACCESS && opMode == M_PC_DISP |=>
    eaOut == $past(pc_r) + 32'($signed($past(opExt0))))
    else $error("pc relative address wrong");
  AST_QUICK: assert property (doIt && opCode == OP_ACCESS && opMode == M_QUICK |=>
    operandOut == 32'($signed($past(opQuick))))
    else $error("quick operand not sign extended");

  COV_NARROW_LONG: cover property (doIt && memOp && opSize == SZ_LONG && !busWide_r);
  COV_REFUSED: cover property (opRefused);
  COV_SUPER_PREDEC: cover property (doIt && superOn && opMode == M_PREDEC && opReg == `STACK_REG);
endmodule : cpu_prog_model
`default_nettype wire

// ===== verif/sys_bus_mem.sv
// Purpose: Far-side memory model that watches each bus beat of the core
// Assumes: Beats last one cycle with no handshake; strap held steady
// Notes: Keeps beat count, first address and last strobe pair of a run
`default_nettype none
module sys_bus_mem (
  // Clock
  input wire logic clk_sys,
  // System bus
  input wire logic busValid,
  input wire logic [31:0] busAddr,
  input wire logic upperByteStrobeN,
  input wire logic lowerByteStrobeN,
  // Observation
  output logic [7:0] beats,
  output logic [1:0] strb,
  output logic [31:0] firstAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prevValid = 1'b0;

  // Count beats of one run; a new run starts when busValid rises
  initial begin
    beats = 8'h00;
    strb = 2'h3;
    firstAddr = 32'h0000_0000;
  end
  always @(posedge clk_sys) begin
    prevValid <= busValid;
    if (busValid) begin
      beats <= prevValid ? beats + 8'h01 : 8'h01;
      strb <= {upperByteStrobeN, lowerByteStrobeN};
      if (!prevValid) begin
        firstAddr <= busAddr;
      end
    end
  end
endmodule : sys_bus_mem
`default_nettype wire

// ===== verif/cpu_core_prog_model_ea_tb.sv
// Purpose: Self-checking bench for the programming model and address unit
// Assumes: One request at a time, next one given in the done cycle
// Notes: Expected answers are queued by the driver and popped on opDone
`default_nettype none
module cpu_core_prog_model_ea_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpu_pm_pkg::*;
  typedef struct {logic rf; logic ce; logic [31:0] ea; logic co; logic [31:0] op;} note_t;
  logic clk_sys, rst, busWidthSel, opValid, opIdxLong;
  op_t opCode;
  eamode_t opMode;
  size_t opSize;
  logic [2:0] opReg;
  logic [3:0] opIdxReg, opDst, rdSel;
  logic [15:0] opExt0, opExt1, statusWord;
  logic [7:0] opQuick, beats;
  logic [31:0] opData, eaOut, operandOut, busAddr, rdData, pcOut, firstAddr, v, d3;
  logic opReady, opDone, opRefused, busValid, upperByteStrobeN, lowerByteStrobeN;
  logic supervisorMode;
  logic [1:0] strb;
  logic [31:0] seed = 32'h0001_18EA;
  int n_mismatch = 0;
  int comparisons = 0;
  note_t notes[$];
  note_t cur;

  cpu_prog_model i_dut (.clk_sys(clk_sys), .rst(rst), .busWidthSel(busWidthSel),
    .opValid(opValid), .opCode(opCode), .opMode(opMode), .opSize(opSize), .opReg(opReg),
    .opIdxReg(opIdxReg), .opIdxLong(opIdxLong), .opDst(opDst), .opExt0(opExt0),
    .opExt1(opExt1), .opQuick(opQuick), .opData(opData), .opReady(opReady),
    .opDone(opDone), .opRefused(opRefused), .eaOut(eaOut), .operandOut(operandOut),
    .busValid(busValid), .busAddr(busAddr), .upperByteStrobeN(upperByteStrobeN),
    .lowerByteStrobeN(lowerByteStrobeN), .rdSel(rdSel), .rdData(rdData),
    .statusWord(statusWord), .pcOut(pcOut), .supervisorMode(supervisorMode));
  sys_bus_mem i_mem (.clk_sys(clk_sys), .busValid(busValid), .busAddr(busAddr),
    .upperByteStrobeN(upperByteStrobeN), .lowerByteStrobeN(lowerByteStrobeN),
    .beats(beats), .strb(strb), .firstAddr(firstAddr));

  // Free-running system clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic cmpv(logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmpv

  // Strap only moves while reset is high, never in operation
  task automatic doReset(logic w);
    @(posedge clk_sys);
    rst <= 1'b1;
    busWidthSel <= w;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask : doReset

  // One request; opIdxLong rides on d[0], quick data on d[7:0]
  task automatic go(op_t c, eamode_t m, size_t s, logic [3:0] r, logic [3:0] x,
                    logic [31:0] e, logic [31:0] d, note_t n);
    logic seen;
    seen = 1'b0;
    notes.push_back(n);
    opValid <= 1'b1;
    opCode <= c;
    opMode <= m;
    opSize <= s;
    opReg <= r[2:0];
    opDst <= r;
    opIdxReg <= x;
    opIdxLong <= d[0];
    {opExt0, opExt1} <= e;
    opQuick <= d[7:0];
    opData <= d;
    @(posedge clk_sys);
    opValid <= 1'b0;
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_sys);
      if (opDone === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    // A lost answer counts as a failure, not a silent skip
    if (!seen) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, 32'h0, 32'h1);
    end
  endtask : go

  task automatic rd(logic [3:0] s, logic [31:0] e);
    rdSel <= s;
    repeat (2) @(posedge clk_sys);
    cmpv(rdData, e);
  endtask : rd

  // Partner updates on the done edge, so look one edge later
  task automatic mem(logic [7:0] b, logic [1:0] st, logic [31:0] a);
    @(posedge clk_sys);
    cmpv(32'(beats), 32'(b));
    cmpv(32'(strb), 32'(st));
    cmpv(firstAddr, a);
  endtask : mem

  task automatic summarize();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Result watcher pops the oldest note on each done pulse
  always @(posedge clk_sys) begin
    if (opDone === 1'b1) begin
      if (notes.size() == 0) begin
        n_mismatch++;
        $display("mismatch at %0t got %h exp %h", $time, 32'h1, 32'h0);
      end else begin
        cur = notes.pop_front();
        cmpv(32'(opRefused), 32'(cur.rf));
        cmpv(32'(opReady), 32'h1);
        if (cur.ce) cmpv(eaOut, cur.ea);
        if (cur.co) cmpv(operandOut, cur.op);
      end
    end
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    rst = 1'b1;
    busWidthSel = 1'b1;
    {opValid, opIdxLong, opReg, opIdxReg, opDst, rdSel} = 17'h0;
    opCode = OP_ACCESS;
    opMode = M_DREG;
    opSize = SZ_BYTE;
    {opExt0, opExt1, opQuick, opData} = 72'h0;
    doReset(1'b1);
    cmpv(32'(statusWord), 32'h0000_2700);
    cmpv(32'(supervisorMode), 32'h1);
    $display("test reset done");
    v = rnd();
    go(OP_REG_WRITE, M_DREG, SZ_LONG, 4'h3, 4'h0, 0, v, '{0, 0, 0, 0, 0});
    go(OP_REG_WRITE, M_DREG, SZ_WORD, 4'h3, 4'h0, 0, 32'h1234, '{0, 0, 0, 0, 0});
    go(OP_REG_WRITE, M_DREG, SZ_BYTE, 4'h3, 4'h0, 0, 32'hAB, '{0, 0, 0, 0, 0});
    d3 = {v[31:16], 16'h12AB};
    rd(4'h3, d3);
    go(OP_REG_WRITE, M_DREG, SZ_LONG, 4'h9, 4'h0, 0, 32'h1000, '{0, 0, 0, 0, 0});
    go(OP_REG_WRITE, M_DREG, SZ_WORD, 4'hA, 4'h0, 0, 32'h8000, '{0, 0, 0, 0, 0});
    rd(4'hA, 32'hFFFF_8000);
    go(OP_REG_WRITE, M_DREG, SZ_BYTE, 4'h9, 4'h0, 0, 32'h55, '{1, 0, 0, 0, 0});
    rd(4'h9, 32'h0000_1000);
    $display("test registers done");
    go(OP_ACCESS, M_DREG, SZ_LONG, 4'h3, 4'h0, 0, 0, '{0, 0, 0, 1, d3});
    go(OP_ACCESS, M_AREG, SZ_BYTE, 4'h1, 4'h0, 0, 0, '{1, 0, 0, 0, 0});
    go(OP_ACCESS, M_AREG, SZ_LONG, 4'h1, 4'h0, 0, 0, '{0, 0, 0, 1, 32'h1000});
    go(OP_ACCESS, M_IND, SZ_WORD, 4'h1, 4'h0, 0, 0, '{0, 1, 32'h1000, 1, 0});
    mem(8'h1, 2'h0, 32'h1000);
    go(OP_ACCESS, M_POSTINC, SZ_LONG, 4'h1, 4'h0, 0, 0, '{0, 1, 32'h1000, 1, 0});
    mem(8'h2, 2'h0, 32'h1000);
    rd(4'h9, 32'h0000_1004);
    go(OP_ACCESS, M_PREDEC, SZ_BYTE, 4'h1, 4'h0, 0, 0, '{0, 1, 32'h1003, 1, 0});
    mem(8'h1, 2'h2, 32'h1003);
    go(OP_ACCESS, M_PREDEC, SZ_BYTE, 4'h7, 4'h0, 0, 0, '{0, 1, 32'hFFFF_FFFE, 1, 0});
    mem(8'h1, 2'h1, 32'hFFFF_FFFE);
    go(OP_ACCESS, M_DISP, SZ_WORD, 4'h1, 4'h0, 32'hFFFC_0000, 0, '{0, 1, 32'hFFF, 1, 0});
    go(OP_ACCESS, M_INDEX, SZ_WORD, 4'h1, 4'h3, 32'h0010_0000, 1,
       '{0, 1, 32'h1013 + d3, 1, 0});
    go(OP_ACCESS, M_INDEX, SZ_WORD, 4'h1, 4'hA, 32'h00F0_0000, 0,
       '{0, 1, 32'hFFFF_8FF3, 1, 0});
    go(OP_ACCESS, M_ABS_S, SZ_WORD, 4'h0, 4'h0, 32'h8000_0000, 0,
       '{0, 1, 32'hFFFF_8000, 1, 0});
    go(OP_ACCESS, M_ABS_L, SZ_WORD, 4'h0, 4'h0, 32'h1234_5678, 0,
       '{0, 1, 32'h1234_5678, 1, 0});
    go(OP_PC_WRITE, M_DREG, SZ_LONG, 4'h0, 4'h0, 0, 32'h400, '{0, 0, 0, 0, 0});
    cmpv(pcOut, 32'h0000_0400);
    go(OP_ACCESS, M_PC_DISP, SZ_WORD, 4'h0, 4'h0, 32'h0010_0000, 0,
       '{0, 1, 32'h410, 1, 0});
    go(OP_ACCESS, M_PC_INDEX, SZ_WORD, 4'h0, 4'h3, 32'h00FE_0000, 1,
       '{0, 1, 32'h3FE + d3, 1, 0});
    go(OP_ACCESS, M_IMM, SZ_LONG, 4'h0, 4'h0, v, 0, '{0, 0, 0, 1, v});
    go(OP_ACCESS, M_QUICK, SZ_LONG, 4'h0, 4'h0, 0, 32'h80, '{0, 0, 0, 1, 32'hFFFF_FF80});
    go(OP_ACCESS, M_IMPLIED, SZ_WORD, 4'h0, 4'h0, 0, 0, '{0, 0, 0, 1, 32'h2700});
    $display("test modes done");
    go(OP_SR_WRITE, M_DREG, SZ_WORD, 4'h0, 4'h0, 0, 0, '{0, 0, 0, 0, 0});
    cmpv(32'(supervisorMode), 32'h0);
    go(OP_SR_WRITE, M_DREG, SZ_WORD, 4'h0, 4'h0, 0, 32'h2700, '{1, 0, 0, 0, 0});
    go(OP_USP_WRITE, M_DREG, SZ_LONG, 4'h0, 4'h0, 0, 32'h80, '{1, 0, 0, 0, 0});
    go(OP_ACCESS, M_IMPLIED, SZ_LONG, 4'h2, 4'h0, 0, 0, '{1, 0, 0, 0, 0});
    go(OP_CCR_WRITE, M_DREG, SZ_BYTE, 4'h0, 4'h0, 0, 32'hFF, '{0, 0, 0, 0, 0});
    cmpv(32'(statusWord), 32'h0000_001F);
    go(OP_ACCESS, M_PREDEC, SZ_BYTE, 4'h7, 4'h0, 0, 0, '{0, 1, 32'hFFFF_FFFE, 1, 0});
    go(OP_ACCESS, M_IMPLIED, SZ_LONG, 4'h1, 4'h0, 0, 0, '{0, 0, 0, 1, 32'hFFFF_FFFE});
    go(OP_ACCESS, M_POSTINC, SZ_BYTE, 4'h7, 4'h0, 0, 0, '{0, 1, 32'hFFFF_FFFE, 1, 0});
    rd(4'hF, 32'h0000_0000);
    $display("test privilege done");
    doReset(1'b0);
    go(OP_REG_WRITE, M_DREG, SZ_LONG, 4'h8, 4'h0, 0, 32'h100, '{0, 0, 0, 0, 0});
    go(OP_ACCESS, M_IND, SZ_LONG, 4'h0, 4'h0, 0, 0, '{0, 1, 32'h100, 1, 0});
    mem(8'h4, 2'h2, 32'h100);
    go(OP_ACCESS, M_IND, SZ_BYTE, 4'h0, 4'h0, 0, 0, '{0, 1, 32'h100, 1, 0});
    mem(8'h1, 2'h0, 32'h100);
    go(OP_ACCESS, M_PREDEC, SZ_LONG, 4'h0, 4'h0, 0, 0, '{0, 1, 32'hFC, 1, 0});
    mem(8'h4, 2'h2, 32'hFC);
    $display("test narrow bus done");
    summarize();
  end
endmodule : cpu_core_prog_model_ea_tb
`default_nettype wire
